// >>> spe_pkg.sv
package spe_pkg;

  // ----------------------------------------------------------------
  // Widths and depths.
  // ----------------------------------------------------------------
  localparam int POS_W      = 24;
  localparam int FIFO_DEPTH = 16;
  localparam int ZCNT_W     = 23;
  localparam int TO_W       = 12;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam longint CLK_HZ       = 40000000;
  localparam longint ZERO_MIN_MS  = 100;
  localparam longint ZERO_MIN_CYC = (CLK_HZ * ZERO_MIN_MS + 999) / 1000;
  localparam longint FRAME_TO_NS  = 20000;
  localparam longint FRAME_TO_CYC =
    (CLK_HZ * FRAME_TO_NS + 999999999) / 1000000000;

  // ----------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_JLIMIT = 5'h08;
  localparam logic [4:0] REG_POS    = 5'h0c;
  localparam logic [4:0] REG_ZERO   = 5'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int CTRL_ZERO_BIT = 0;
  localparam int CTRL_JCLR_BIT = 1;
  localparam int ST_JUMP_BIT   = 0;
  localparam int ST_MT_BIT     = 1;
  localparam int ST_DIR_BIT    = 2;
  localparam int ST_FRAME_BIT  = 3;
  localparam int ST_EMPTY_BIT  = 4;
  localparam logic [POS_W-1:0] JLIMIT_RST = 24'h000100;

  // ----------------------------------------------------------------
  // Pin group carried through the synchroniser.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clk_p;
    logic clk_n;
    logic zero;
    logic dir_level;
    logic dir_float;
    logic mt_low;
  } spe_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_HOLD
  } spe_state_t;

endpackage : spe_pkg

// >>> spe_sync.sv
`timescale 1ns/1ps

module spe_sync
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire spe_pkg::spe_pins_t pins_in,
  output spe_pkg::spe_pins_t      pins_out
);

  localparam int W = $bits(spe_pkg::spe_pins_t);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] raw;

  assign raw      = pins_in;
  assign pins_out = stage2;

  // ----------------------------------------------------------------
  // Two flip-flops per pin.
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= raw[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule : spe_sync

// >>> spe_fifo.sv
`timescale 1ns/1ps

module spe_fifo
#(
  parameter int W     = 24,
  parameter int DEPTH = 16
)
(
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic [AW:0]   next_count;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign out_data   = mem[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr    <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr    <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count     <= next_count;
      in_ready  <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

endmodule : spe_fifo

// >>> spe_encoder_port.sv
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module spe_encoder_port
#(
  parameter longint ZERO_MIN = spe_pkg::ZERO_MIN_CYC
)
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ssi_clk_p,
  input  wire logic        ssi_clk_n,
  output logic             ssi_data_p,
  output logic             ssi_data_n,
  input  wire logic        zero_pin,
  input  wire logic        dir_pin,
  input  wire logic        dir_pin_open,
  input  wire logic        mt_supply_low,
  input  wire logic        pos_valid,
  output logic             pos_ready,
  input  wire logic [23:0] pos_data,
  output logic             word_jump_fault_pin,
  output logic             multiturn_supply_fault_pin
);

  localparam int PW = spe_pkg::POS_W;
  localparam int ZCNT_W_L = spe_pkg::ZCNT_W;
  localparam logic [ZCNT_W_L-1:0] ZLAST = ZCNT_W_L'(ZERO_MIN - 1);
  localparam int TO_W_L = spe_pkg::TO_W;
  localparam logic [TO_W_L-1:0] TO_LAST =
    TO_W_L'(spe_pkg::FRAME_TO_CYC - 1);

  // ----------------------------------------------------------------
  // Pin synchronisation.
  // ----------------------------------------------------------------
  spe_pkg::spe_pins_t pins_raw;
  spe_pkg::spe_pins_t pins;

  assign pins_raw = '{clk_p:     ssi_clk_p,
                      clk_n:     ssi_clk_n,
                      zero:      zero_pin,
                      dir_level: dir_pin,
                      dir_float: dir_pin_open,
                      mt_low:    mt_supply_low};

  spe_sync u_sync
  (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .pins_in  (pins_raw),
    .pins_out (pins)
  );

  // ----------------------------------------------------------------
  // Position buffer.
  // ----------------------------------------------------------------
  logic          f_valid;
  logic [PW-1:0] f_data;
  wire           f_pop;

  spe_fifo #(.W(PW), .DEPTH(spe_pkg::FIFO_DEPTH)) u_fifo
  (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (pos_valid),
    .in_ready  (pos_ready),
    .in_data   (pos_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  // ----------------------------------------------------------------
  // Decoding.
  // ----------------------------------------------------------------
  spe_pkg::spe_state_t state;
  spe_pkg::spe_state_t next_state;
  logic                clk_prev;
  logic [PW-1:0]       raw_cur;
  logic [PW-1:0]       zero_ofs;
  logic [PW-1:0]       shreg;
  logic [PW-1:0]       last_in;
  logic                have_last;
  logic [PW-1:0]       jlimit;
  logic                jump_flag;
  logic [ZCNT_W_L-1:0] zero_cnt;
  logic [4:0]          bitcnt;
  logic [spe_pkg::TO_W-1:0] to_cnt;

  wire clk_lvl  = pins.clk_p & ~pins.clk_n;
  wire clk_fall = clk_prev & ~clk_lvl;
  wire clk_rise = ~clk_prev & clk_lvl;
  wire dir_eff  = pins.dir_float | pins.dir_level;

  wire [PW-1:0] src = f_valid ? f_data : raw_cur;
  wire [PW-1:0] adj = dir_eff ? src : ~src;
  wire [PW-1:0] rep = adj - zero_ofs;

  wire frame_start = (state == spe_pkg::ST_IDLE) && clk_fall;
  assign f_pop     = frame_start;
  wire timed_out   = (state != spe_pkg::ST_IDLE) && !clk_rise
                     && !clk_fall && (to_cnt == TO_LAST);

  wire accept_in = pos_valid && pos_ready;
  wire [PW-1:0] diff_a = pos_data - last_in;
  wire [PW-1:0] diff_b = last_in - pos_data;
  wire [PW-1:0] diff   = diff_a[PW-1] ? diff_b : diff_a;
  wire jump_seen = accept_in && have_last && (diff > jlimit);

  wire zero_fire = pins.zero && (zero_cnt == ZLAST);

  wire [4:0] rd_off   = {avs_address, 2'b00};
  wire       req      = avs_read || avs_write;
  wire       wr_take  = avs_write && !avs_waitrequest;
  wire       wr_ctrl  = wr_take && rd_off == spe_pkg::REG_CTRL;
  wire       wr_jlim  = wr_take && rd_off == spe_pkg::REG_JLIMIT;
  wire       soft_zero = wr_ctrl && avs_writedata[spe_pkg::CTRL_ZERO_BIT];
  wire       jump_clr  = wr_ctrl && avs_writedata[spe_pkg::CTRL_JCLR_BIT];
  wire       do_zero   = zero_fire || soft_zero;

  wire [31:0] status = {27'h0,
                        f_valid ? 1'b0 : 1'b1,
                        state != spe_pkg::ST_IDLE,
                        dir_eff,
                        pins.mt_low,
                        jump_flag};
  wire [31:0] rd_mux =
    (rd_off == spe_pkg::REG_STATUS) ? status :
    (rd_off == spe_pkg::REG_JLIMIT) ? {8'h0, jlimit} :
    (rd_off == spe_pkg::REG_POS)    ? {8'h0, rep} :
    (rd_off == spe_pkg::REG_ZERO)   ? {8'h0, zero_ofs} : 32'h0;

  always_comb
  begin
    next_state = state;
    case (state)
      spe_pkg::ST_IDLE:
        if (clk_fall)
          next_state = spe_pkg::ST_SHIFT;
      spe_pkg::ST_SHIFT:
        if (timed_out)
          next_state = spe_pkg::ST_IDLE;
        else if (clk_rise && bitcnt == 5'h01)
          next_state = spe_pkg::ST_HOLD;
      spe_pkg::ST_HOLD:
        if (timed_out)
          next_state = spe_pkg::ST_IDLE;
      default:
        next_state = spe_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial frame.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state    <= spe_pkg::ST_IDLE;
      clk_prev <= 1'b0;
      to_cnt   <= '0;
      bitcnt   <= '0;
      shreg    <= '0;
      raw_cur  <= '0;
    end
    else
    begin
      state    <= next_state;
      clk_prev <= clk_lvl;
      to_cnt   <= (clk_rise || clk_fall) ? '0 : to_cnt + 1'b1;
      if (frame_start)
      begin
        shreg   <= rep;
        bitcnt  <= 5'(PW);
        raw_cur <= src;
      end
      else if (state == spe_pkg::ST_SHIFT && clk_rise)
      begin
        shreg  <= {shreg[PW-2:0], 1'b0};
        bitcnt <= bitcnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ssi_data_p <= 1'b1;
      ssi_data_n <= 1'b0;
    end
    else if (state == spe_pkg::ST_SHIFT && clk_rise)
    begin
      ssi_data_p <= shreg[PW-1];
      ssi_data_n <= ~shreg[PW-1];
    end
    else if (state == spe_pkg::ST_HOLD && clk_rise)
    begin
      ssi_data_p <= 1'b0;
      ssi_data_n <= 1'b1;
    end
    else if (next_state == spe_pkg::ST_IDLE)
    begin
      ssi_data_p <= 1'b1;
      ssi_data_n <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Zeroing.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      zero_cnt <= '0;
      zero_ofs <= '0;
    end
    else
    begin
      if (!pins.zero)
        zero_cnt <= '0;
      else if (zero_cnt != ZLAST + 1'b1)
        zero_cnt <= zero_cnt + 1'b1;
      if (do_zero)
        zero_ofs <= adj;
    end
  end

  // ----------------------------------------------------------------
  // Diagnostics.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      last_in   <= '0;
      have_last <= 1'b0;
      jump_flag <= 1'b0;
      word_jump_fault_pin        <= 1'b1;
      multiturn_supply_fault_pin <= 1'b1;
    end
    else
    begin
      if (accept_in)
      begin
        last_in   <= pos_data;
        have_last <= 1'b1;
      end
      jump_flag <= jump_seen || (jump_flag && !jump_clr);
      word_jump_fault_pin        <= ~(jump_seen || jump_flag);
      multiturn_supply_fault_pin <= ~pins.mt_low;
    end
  end

  // ----------------------------------------------------------------
  // Register bus.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
      jlimit          <= spe_pkg::JLIMIT_RST;
    end
    else
    begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest)
        avs_readdata <= avs_read ? rd_mux : 32'h0;
      if (wr_jlim)
        jlimit <= avs_writedata[PW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  sequence s_first_fall;
    state == spe_pkg::ST_IDLE && clk_fall;
  endsequence

  sequence s_shift_edge;
    state == spe_pkg::ST_SHIFT && clk_rise;
  endsequence

  property p_data_compl;
    @(posedge sys_clk) disable iff (sys_rst)
    ssi_data_n == !ssi_data_p;
  endproperty
  a_data_compl: assert property (p_data_compl)
    else $error("Data lines are not complementary.");

  property p_zero_load;
    @(posedge sys_clk) disable iff (sys_rst)
    do_zero |=> zero_ofs == $past(adj);
  endproperty
  a_zero_load: assert property (p_zero_load)
    else $error("Zero offset not taken from position.");

  property p_zero_min;
    @(posedge sys_clk) disable iff (sys_rst)
    zero_fire |-> $past(pins.zero) && zero_cnt == ZLAST;
  endproperty
  a_zero_min: assert property (p_zero_min)
    else $error("Zeroing fired before the minimum pulse time.");

  property p_dir_open;
    @(posedge sys_clk) disable iff (sys_rst)
    pins.dir_float |-> adj == src;
  endproperty
  a_dir_open: assert property (p_dir_open)
    else $error("Open direction input not counted as high.");

  property p_dir_low;
    @(posedge sys_clk) disable iff (sys_rst)
    !dir_eff |-> adj == ~src;
  endproperty
  a_dir_low: assert property (p_dir_low)
    else $error("Low direction does not invert the count.");

  property p_jump_pin;
    @(posedge sys_clk) disable iff (sys_rst)
    jump_seen |=> !word_jump_fault_pin && jump_flag;
  endproperty
  a_jump_pin: assert property (p_jump_pin)
    else $error("Jump fault pin did not go low.");

  property p_mt_pin;
    @(posedge sys_clk) disable iff (sys_rst)
    pins.mt_low ##1 pins.mt_low |-> !multiturn_supply_fault_pin;
  endproperty
  a_mt_pin: assert property (p_mt_pin)
    else $error("Multiturn fault pin not low on low supply.");

  property p_latch;
    @(posedge sys_clk) disable iff (sys_rst)
    s_first_fall |=> shreg == $past(rep) && bitcnt == 5'(PW);
  endproperty
  a_latch: assert property (p_latch)
    else $error("Position not latched at frame start.");

  property p_shift;
    @(posedge sys_clk) disable iff (sys_rst)
    s_shift_edge |=> ssi_data_p == $past(shreg[PW-1]);
  endproperty
  a_shift: assert property (p_shift)
    else $error("Data bit is not the shift register MSB.");

  property p_bus_answer;
    @(posedge sys_clk) disable iff (sys_rst)
    req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Bus answer not one cycle after request.");

endmodule : spe_encoder_port

// >>> spe_ssi_master.sv
`timescale 1ns/1ps

module spe_ssi_master
(
  input  wire logic data_p,
  input  wire logic data_n,
  output logic      clk_p,
  output logic      clk_n
);

  // ----------------------------------------------------------------
  // Clock loop, idle high and still between frames.
  // ----------------------------------------------------------------
  assign clk_n = ~clk_p;

  initial clk_p = 1'b1;

  // One read of 24 bits. The flags report line complement, the low
  // hold after the last bit, and the return to idle after the pause.
  task automatic frame(output logic [23:0] word, output logic [2:0] ok);
    ok   = 3'h7;
    word = 24'h000000;
    #3;
    clk_p = 1'b0;
    #100;
    for (int i = 1; i <= 25; i++)
    begin
      if (i > 1)
      begin
        word = {word[22:0], data_p};
        if (data_n !== ~data_p)
          ok[0] = 1'b0;
      end
      clk_p = 1'b1;
      #100;
      if (i < 25)
      begin
        clk_p = 1'b0;
        #100;
      end
    end
    #200;
    if (data_p !== 1'b0 || data_n !== 1'b1)
      ok[1] = 1'b0;
    #22000;
    if (data_p !== 1'b1 || data_n !== 1'b0)
      ok[2] = 1'b0;
  endtask : frame

endmodule : spe_ssi_master

// >>> spe_encoder_port_bench.sv
`timescale 1ns/1ps

module spe_encoder_port_bench;

  localparam logic [2:0] A_CTRL = spe_pkg::REG_CTRL[4:2];
  localparam logic [2:0] A_STAT = spe_pkg::REG_STATUS[4:2];
  localparam logic [2:0] A_JLIM = spe_pkg::REG_JLIMIT[4:2];
  localparam logic [2:0] A_POS  = spe_pkg::REG_POS[4:2];
  localparam logic [2:0] A_ZERO = spe_pkg::REG_ZERO[4:2];

  logic        sys_clk;
  logic        sys_rst;
  logic [2:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ssi_clk_p;
  logic        ssi_clk_n;
  logic        ssi_data_p;
  logic        ssi_data_n;
  logic        zero_pin;
  logic        dir_pin;
  logic        dir_pin_open;
  logic        mt_supply_low;
  logic        pos_valid;
  logic        pos_ready;
  logic [23:0] pos_data;
  logic        word_jump_fault_pin;
  logic        multiturn_supply_fault_pin;
  int          err_count;
  int          cmp_count;
  int          k;
  logic [31:0] rd;

  spe_encoder_port #(.ZERO_MIN(20)) dut
  (
    .sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .ssi_clk_p,
    .ssi_clk_n, .ssi_data_p, .ssi_data_n, .zero_pin, .dir_pin,
    .dir_pin_open, .mt_supply_low, .pos_valid, .pos_ready, .pos_data,
    .word_jump_fault_pin, .multiturn_supply_fault_pin
  );

  spe_ssi_master link
  (
    .data_p (ssi_data_p),
    .data_n (ssi_data_n),
    .clk_p  (ssi_clk_p),
    .clk_n  (ssi_clk_n)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50)
    begin
      chk("waitrequest", 32'h0, 32'h1);
      results();
    end
  endtask : bus

  task automatic push(input logic [23:0] v);
    int n;
    n = 0;
    @(posedge sys_clk);
    pos_valid <= 1'b1;
    pos_data  <= v;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pos_ready !== 1'b1 && n < 50);
    pos_valid <= 1'b0;
    if (n >= 50)
    begin
      chk("pos_ready", 32'h1, 32'h0);
      results();
    end
  endtask : push

  task automatic frame_chk(input string name, input logic [23:0] exp);
    logic [23:0] w;
    logic [2:0]  ok;
    link.frame(w, ok);
    chk(name, 32'(exp), 32'(w));
    chk("data_lines", 32'h7, 32'(ok));
  endtask : frame_chk

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    chk("watchdog", 32'h0, 32'h1);
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial
  begin
    err_count = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    zero_pin = 1'b0;
    dir_pin = 1'b1;
    dir_pin_open = 1'b0;
    mt_supply_low = 1'b0;
    pos_valid = 1'b0;
    pos_data = 24'h000000;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("waitrequest", 32'h1, 32'(avs_waitrequest));
    chk("data_p", 32'h1, 32'(ssi_data_p));
    chk("data_n", 32'h0, 32'(ssi_data_n));
    chk("jump_pin", 32'h1, 32'(word_jump_fault_pin));
    chk("mt_pin", 32'h1, 32'(multiturn_supply_fault_pin));
    bus(1'b0, A_JLIM, 32'h0, rd);
    chk("jump_limit", 32'(spe_pkg::JLIMIT_RST), rd);
    bus(1'b0, A_STAT, 32'h0, rd);
    chk("status", 32'h14, rd);
    bus(1'b1, A_JLIM, 32'h00ffffff, rd);
    bus(1'b0, A_JLIM, 32'h0, rd);
    chk("jump_limit", 32'h00ffffff, rd);
    bus(1'b1, A_POS, 32'h00abcdef, rd);
    bus(1'b0, A_POS, 32'h0, rd);
    chk("position", 32'h0, rd);
    bus(1'b0, 3'h5, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    $display("test reset and registers done");
    for (int i = 0; i < 3; i++)
    begin
      dir_pin      <= (i == 0);
      dir_pin_open <= (i == 2);
      push(24'h123456 + 24'(i));
      frame_chk("frame", (i == 1) ? ~(24'h123457) : 24'h123456 + 24'(i));
    end
    bus(1'b0, A_POS, 32'h0, rd);
    chk("position", 32'h00123458, rd);
    dir_pin      <= 1'b1;
    dir_pin_open <= 1'b0;
    $display("test direction done");
    bus(1'b1, A_JLIM, 32'h00000010, rd);
    push(24'h200000);
    frame_chk("frame", 24'h200000);
    bus(1'b1, A_CTRL, 32'h2, rd);
    push(24'h200010);
    frame_chk("frame", 24'h200010);
    chk("jump_pin", 32'h1, 32'(word_jump_fault_pin));
    push(24'h200051);
    frame_chk("frame", 24'h200051);
    chk("jump_pin", 32'h0, 32'(word_jump_fault_pin));
    bus(1'b0, A_STAT, 32'h0, rd);
    chk("status_jump", 32'h1, 32'(rd[0]));
    bus(1'b1, A_CTRL, 32'h2, rd);
    repeat (3) @(posedge sys_clk);
    chk("jump_pin", 32'h1, 32'(word_jump_fault_pin));
    bus(1'b1, A_JLIM, 32'h00ffffff, rd);
    $display("test jump done");
    mt_supply_low <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("mt_pin", 32'h0, 32'(multiturn_supply_fault_pin));
    bus(1'b0, A_STAT, 32'h0, rd);
    chk("status_mt", 32'h1, 32'(rd[1]));
    mt_supply_low <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("mt_pin", 32'h1, 32'(multiturn_supply_fault_pin));
    $display("test multiturn done");
    k = 0;
    @(posedge sys_clk);
    pos_valid <= 1'b1;
    pos_data  <= 24'h300000;
    repeat (20)
    begin
      @(posedge sys_clk);
      if (pos_ready === 1'b1)
      begin
        k++;
        pos_data <= 24'h300000 + 24'(k);
      end
    end
    pos_valid <= 1'b0;
    chk("fifo_count", 32'd16, 32'(k));
    bus(1'b0, A_STAT, 32'h0, rd);
    chk("status_empty", 32'h0, 32'(rd[4]));
    for (int i = 0; i < 16; i++)
      frame_chk("frame", 24'h300000 + 24'(i));
    bus(1'b0, A_STAT, 32'h0, rd);
    chk("status_empty", 32'h1, 32'(rd[4]));
    $display("test buffer done");
    dir_pin <= 1'b1;
    zero_pin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    zero_pin <= 1'b0;
    repeat (5) @(posedge sys_clk);
    bus(1'b0, A_ZERO, 32'h0, rd);
    chk("zero_offset", 32'h0, rd);
    zero_pin <= 1'b1;
    repeat (30) @(posedge sys_clk);
    zero_pin <= 1'b0;
    repeat (5) @(posedge sys_clk);
    bus(1'b0, A_ZERO, 32'h0, rd);
    chk("zero_offset", 32'h0030000f, rd);
    bus(1'b0, A_POS, 32'h0, rd);
    chk("position", 32'h0, rd);
    push(24'h300014);
    frame_chk("frame", 24'h000005);
    bus(1'b1, A_CTRL, 32'h1, rd);
    bus(1'b0, A_ZERO, 32'h0, rd);
    chk("zero_offset", 32'h00300014, rd);
    $display("test zero done");
    results();
  end

endmodule : spe_encoder_port_bench
